// ===== rtl/sync_serial_regs.vh
// constants for the clocked synchronous character link
// assumes inclusion by bare name from the rtl modules
`ifndef SYNC_SERIAL_REGS_VH
`define SYNC_SERIAL_REGS_VH

// clock source select codes (two-bit setting)
`define CKSRC_INT_A      2'b00
`define CKSRC_INT_B      2'b01
`define CKSRC_EXT_A      2'b10
`define CKSRC_EXT_B      2'b11
// bits per character
`define CHAR_BITS        4'h8
`define BIT_CNT_ZERO     4'h0
// default half period of internal serial clock in system cycles
`define HALF_PERIOD_DEF  8'h04
`define HALF_CNT_ONE     8'h01
// serial clock idle level
`define SCK_IDLE         1'b1
// reset contents of the data registers and idle level of the data line
`define BYTE_RESET       8'h00
`define TXD_IDLE         1'b1

`endif

// ===== rtl/pin_sync.v
// two flip-flop synchroniser for one asynchronous level
// assumes the input is a pin outside the system clock domain
`timescale 1ns/1ps

module pin_sync
(
    // clock and reset
    input  wire clk,
    input  wire rst,
    // level in and out
    input  wire din,
    output wire dout
);

reg meta_ff;
reg sync_ff;

// first stage feeds only the second stage
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        meta_ff <= 1'b1;
        sync_ff <= 1'b1;
    end
    else
    begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end
end

assign dout = sync_ff;

endmodule // pin_sync

// ===== rtl/sck_gen.v
// internal bit-rate generator: divides the system clock into serial clock ticks
// assumes half_period is held stable while a character is being clocked
`timescale 1ns/1ps
`include "sync_serial_regs.vh"

module sck_gen
#(
    parameter HALF_W = 8
)
(
    // clock and reset
    input  wire              clk,
    input  wire              rst,
    // control
    input  wire              run,
    input  wire [HALF_W-1:0] half_period,
    // one-cycle toggle request
    output wire              tick
);

reg [HALF_W-1:0] cnt_ff;
reg [HALF_W-1:0] nxt_cnt;

// count down each half period; restart when stopped so the first half is full length
always @*
begin
    nxt_cnt = cnt_ff;
    if (!run || cnt_ff <= `HALF_CNT_ONE)
        nxt_cnt = half_period;
    else
        nxt_cnt = cnt_ff - `HALF_CNT_ONE;
end

always @(posedge clk or posedge rst)
begin
    if (rst)
        cnt_ff <= `HALF_PERIOD_DEF;
    else
        cnt_ff <= nxt_cnt;
end

assign tick = run && (cnt_ff <= `HALF_CNT_ONE);

endmodule // sck_gen

// ===== rtl/sync_serial_link.v
// clocked synchronous character link: 8-bit, lsb first, double-buffered tx and rx
// assumes an external serial clock is below one sixth of CLK_SYS and that
// the user-side strobes come from logic on CLK_SYS
// limitation: external clock edges are seen about three system cycles late,
// so the far side must hold data that long after each rising edge
// an overrun drops the new character so the unread one is never torn
`timescale 1ns/1ps
`include "sync_serial_regs.vh"

module sync_serial_link
#(
    parameter HALF_W = 8
)
(
    // system clock and reset
    input  wire              CLK_SYS,
    input  wire              SYS_RST,
    // configuration
    input  wire [1:0]        CLK_SRC_SEL,
    input  wire [HALF_W-1:0] HALF_PERIOD,
    input  wire              TX_ENABLE,
    input  wire              RX_ENABLE,
    // transmit buffer write side
    input  wire [7:0]        TX_DATA,
    input  wire              TX_VALID,
    output wire              TX_READY,
    output wire              TX_BUSY,
    // receive buffer read side
    output wire [7:0]        RX_DATA,
    output wire              RX_VALID,
    input  wire              RX_READ,
    output wire              RX_OVERRUN,
    // serial pins
    input  wire              SCK_IN,
    output wire              SCK_OUT,
    output wire              SCK_OE,
    input  wire              RXD,
    output wire              TXD
);

// ----------------------------------------------------------------
// clock source and pin synchronisers
// ----------------------------------------------------------------
wire int_clk;
wire sck_in_s;
wire rxd_s;
wire gen_tick;

// codes 00/01 pick the internal generator, 10/11 the pin
assign int_clk = (CLK_SRC_SEL == `CKSRC_INT_A) || (CLK_SRC_SEL == `CKSRC_INT_B);

// clock and data share one synchroniser depth so their edges stay aligned
pin_sync u_sck_sync
(
    .clk  (CLK_SYS),
    .rst  (SYS_RST),
    .din  (SCK_IN),
    .dout (sck_in_s)
);

pin_sync u_rxd_sync
(
    .clk  (CLK_SYS),
    .rst  (SYS_RST),
    .din  (RXD),
    .dout (rxd_s)
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
// one-hot sequencer states
localparam ST_IDLE  = 2'b01;
localparam ST_SHIFT = 2'b10;

// sequencer, serial clock and bit counter
reg [1:0] state_ff;
reg [1:0] nxt_state;
reg       sck_int_ff;
reg       nxt_sck_int;
reg       sck_ext_d_ff;
reg [3:0] bit_cnt_ff;
reg [3:0] nxt_bit_cnt;

// transmit buffer, shifter and line
reg [7:0] tx_buf_ff;
reg [7:0] nxt_tx_buf;
reg       tx_full_ff;
reg       nxt_tx_full;
reg [7:0] tx_sh_ff;
reg [7:0] nxt_tx_sh;
reg       txd_ff;
reg       nxt_txd;

// receive shifter, buffer and overrun
reg [7:0] rx_sh_ff;
reg [7:0] nxt_rx_sh;
reg [7:0] rx_buf_ff;
reg [7:0] nxt_rx_buf;
reg       rx_full_ff;
reg       nxt_rx_full;
reg       ovr_ff;
reg       nxt_ovr;

// generator runs only while clocking a character internally
// trade-off: it restarts for each character, so a gap lasts a full half period
sck_gen #(.HALF_W(HALF_W)) u_gen
(
    .clk         (CLK_SYS),
    .rst         (SYS_RST),
    .run         (int_clk && state_ff == ST_SHIFT),
    .half_period (HALF_PERIOD),
    .tick        (gen_tick)
);

// ----------------------------------------------------------------
// serial clock edge detection
// ----------------------------------------------------------------
wire fall_edge;
wire rise_edge;

// internal: a tick while high is a falling edge, while low a rising edge
// external: the synchronised pin against its one-cycle-old copy
// a fall and a rise can never come in the same cycle
assign fall_edge = int_clk ? (gen_tick && sck_int_ff) : (sck_ext_d_ff && !sck_in_s);
assign rise_edge = int_clk ? (gen_tick && !sck_int_ff) : (!sck_ext_d_ff && sck_in_s);

// ----------------------------------------------------------------
// shift engine
// ----------------------------------------------------------------
// load and end-of-character strobes, one system cycle each
wire tx_load;
wire char_done;

// a character starts when data waits at the first falling edge, or at once for internal clock
// loads happen only from idle, so a character is never cut short
assign tx_load   = tx_full_ff && TX_ENABLE && (state_ff == ST_IDLE) && (int_clk || fall_edge);
// the eighth rising edge closes a character
assign char_done = rise_edge && (bit_cnt_ff == `CHAR_BITS - 4'h1);

// next-state logic: sequencer, serial clock and both shifters
always @*
begin
    nxt_state   = state_ff;
    nxt_sck_int = sck_int_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_txd     = txd_ff;
    nxt_rx_sh   = rx_sh_ff;
    case (state_ff)
        ST_IDLE:
        begin
            nxt_sck_int = `SCK_IDLE;
            nxt_bit_cnt = `BIT_CNT_ZERO;
            if (tx_load)
            begin
                // first bit goes out at once: acts as the opening falling edge
                nxt_txd   = tx_buf_ff[0];
                nxt_tx_sh = {1'b0, tx_buf_ff[7:1]};
                nxt_state = ST_SHIFT;
            end
            // external receive-only frame opens at the first falling edge
            else if (!int_clk && RX_ENABLE && fall_edge)
                nxt_state = ST_SHIFT;
        end
        ST_SHIFT:
        begin
            // internal clock toggles on every generator tick
            if (int_clk && gen_tick)
                nxt_sck_int = !sck_int_ff;
            // later falls put out the next bit; the first went out at load
            if (fall_edge && bit_cnt_ff != `BIT_CNT_ZERO)
            begin
                nxt_txd   = tx_sh_ff[0];
                nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
            end
            // each rising edge takes one receive bit, lsb lands first
            if (rise_edge)
            begin
                nxt_rx_sh   = {rxd_s, rx_sh_ff[7:1]};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
            // stop after the eighth rising edge; clock rests high
            if (char_done)
            begin
                nxt_state   = ST_IDLE;
                nxt_sck_int = `SCK_IDLE;
            end
        end
        default:
        begin
            // an illegal code falls back to idle
            nxt_state = ST_IDLE;
        end
    endcase
end

// ----------------------------------------------------------------
// double buffers
// ----------------------------------------------------------------
// set wins over read/write clear so no event is lost
always @*
begin
    nxt_tx_buf  = tx_buf_ff;
    nxt_tx_full = tx_full_ff;
    // a write in the load cycle refills the buffer at once
    if (tx_load)
        nxt_tx_full = 1'b0;
    if (TX_VALID && (!tx_full_ff || tx_load))
    begin
        nxt_tx_buf  = TX_DATA;
        nxt_tx_full = 1'b1;
    end
    // a read and a new character in one cycle keep the new one
    nxt_rx_buf  = rx_buf_ff;
    nxt_rx_full = rx_full_ff;
    nxt_ovr     = ovr_ff;
    if (RX_READ)
    begin
        nxt_rx_full = 1'b0;
        nxt_ovr     = 1'b0;
    end
    if (char_done && RX_ENABLE)
    begin
        // overrun: the unread byte stays whole, the new one is dropped
        if (rx_full_ff && !RX_READ)
            nxt_ovr = 1'b1;                                            // keep old byte
        else
        begin
            nxt_rx_buf  = {rxd_s, rx_sh_ff[7:1]};
            nxt_rx_full = 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
// every register updates each system edge; reset loads only constants
always @(posedge CLK_SYS or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        state_ff     <= ST_IDLE;
        sck_int_ff   <= `SCK_IDLE;
        sck_ext_d_ff <= `SCK_IDLE;
        bit_cnt_ff   <= `BIT_CNT_ZERO;
        tx_buf_ff    <= `BYTE_RESET;
        tx_full_ff   <= 1'b0;
        tx_sh_ff     <= `BYTE_RESET;
        // the line rests high until the first character
        txd_ff       <= `TXD_IDLE;
        rx_sh_ff     <= `BYTE_RESET;
        rx_buf_ff    <= `BYTE_RESET;
        rx_full_ff   <= 1'b0;
        ovr_ff       <= 1'b0;
    end
    else
    begin
        state_ff     <= nxt_state;
        sck_int_ff   <= nxt_sck_int;
        sck_ext_d_ff <= sck_in_s;
        bit_cnt_ff   <= nxt_bit_cnt;
        tx_buf_ff    <= nxt_tx_buf;
        tx_full_ff   <= nxt_tx_full;
        tx_sh_ff     <= nxt_tx_sh;
        txd_ff       <= nxt_txd;
        rx_sh_ff     <= nxt_rx_sh;
        rx_buf_ff    <= nxt_rx_buf;
        rx_full_ff   <= nxt_rx_full;
        ovr_ff       <= nxt_ovr;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
// data only, no parity slot exists in the shifter
assign TXD        = txd_ff;
assign SCK_OUT    = sck_int_ff;
assign SCK_OE     = int_clk;
// handshake flags decode straight from registers
assign TX_READY   = !tx_full_ff;
assign TX_BUSY    = (state_ff == ST_SHIFT) || tx_full_ff;
// receive data and status come straight from flip-flops
assign RX_DATA    = rx_buf_ff;
assign RX_VALID   = rx_full_ff;
assign RX_OVERRUN = ovr_ff;

endmodule // sync_serial_link

// ===== verification/sync_serial_link_assertions.sv
// port checker for the synchronous character link
// assumes the bind below; internal source while select bit 1 is low
`timescale 1ns/1ps
module sync_serial_link_assertions
(
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       SYS_RST,
    // user side
    input wire logic [1:0] CLK_SRC_SEL,
    input wire logic       TX_VALID,
    input wire logic       TX_READY,
    input wire logic       TX_BUSY,
    input wire logic [7:0] RX_DATA,
    input wire logic       RX_VALID,
    input wire logic       RX_READ,
    input wire logic       RX_OVERRUN,
    // serial pins
    input wire logic       SCK_OUT,
    input wire logic       SCK_OE,
    input wire logic       TXD
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // the enable may be registered, so it is judged once the select has settled
    wire logic int_src = !CLK_SRC_SEL[1];
    property p_oe; $stable(CLK_SRC_SEL)[*2] |-> SCK_OE == int_src; endproperty
    a_oe: assert property (p_oe) else $error("clock enable wrong");
    property p_idle; int_src && TX_READY && !TX_BUSY |-> SCK_OUT; endproperty
    a_idle: assert property (p_idle) else $error("idle clock not high");
    property p_start; int_src && $fell(SCK_OUT) |-> TX_BUSY; endproperty
    a_start: assert property (p_start) else $error("clock without data");
    property p_take; TX_VALID && TX_READY |=> !TX_READY; endproperty
    a_take: assert property (p_take) else $error("buffer not taken");
    property p_low; int_src && !SCK_OUT && !$past(SCK_OUT) |-> $stable(TXD); endproperty
    a_low: assert property (p_low) else $error("data moved while clock low");
    property p_rise; int_src && $rose(SCK_OUT) |-> $stable(TXD); endproperty
    a_rise: assert property (p_rise) else $error("data moved at rise");
    property p_msb; int_src && !TX_BUSY && !$past(TX_BUSY) |-> $stable(TXD); endproperty
    a_msb: assert property (p_msb) else $error("idle line moved");
    property p_hold; RX_VALID && !RX_READ |=> RX_VALID && $stable(RX_DATA); endproperty
    a_hold: assert property (p_hold) else $error("receive buffer lost");
    // three quiet cycles first, so no byte can still be landing
    property p_clear; (int_src && !TX_BUSY)[*3] ##0 RX_READ |=> !RX_VALID && !RX_OVERRUN; endproperty
    a_clear: assert property (p_clear) else $error("read did not clear");
endmodule // sync_serial_link_assertions

bind sync_serial_link sync_serial_link_assertions i_sync_serial_link_assertions
(
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CLK_SRC_SEL(CLK_SRC_SEL), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_READ(RX_READ), .RX_OVERRUN(RX_OVERRUN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .TXD(TXD)
);

// ===== verification/serial_peer.sv
// behavioural far-side peer: shifts on falls, samples on rises
// assumes rst is high from time zero; one frame per rise of go
`timescale 1ns/1ps
module serial_peer
(
    // reset and pins
    input  wire logic       rst,
    input  wire logic       sck_oe,
    input  wire logic       sck_out,
    input  wire logic       txd,
    output logic            sck_in = 1'b1,
    output logic            rxd = 1'b1,
    // test control
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte = 8'h00,
    output int              frames = 0
);
    logic [7:0] sh;
    logic [7:0] acc;
    int         n = 0;
    wire        sck = sck_oe ? sck_out : sck_in;
    // external clock: 200 ns period, standing high between frames
    always @(posedge go)
        repeat (8)
        begin
            #100 sck_in = 1'b0;
            #100 sck_in = 1'b1;
        end
    // next bit on each fall, lsb first
    always @(negedge sck)
    begin
        if (!rst && n == 0)
            sh = tx_byte;
        if (!rst)
            rxd = sh[0];
        sh = sh >> 1;
    end
    // sample on rises; half a bit after the last rise the line shows the inverse,
    // not a held bit: the device sees external edges late and needs that hold
    always @(posedge sck)
        if (!rst)
        begin
            acc = {txd, acc[7:1]};
            n = n + 1;
            if (n == 8)
            begin
                n = 0;
                rx_byte = acc;
                frames = frames + 1;
                rxd <= #100 ~rxd;
            end
        end
endmodule // serial_peer

// ===== verification/sync_serial_link_tb.sv
// self-checking bench for the synchronous character link
// assumes serial_peer on the far side and the bound port checker
`timescale 1ns/1ps
module sync_serial_link_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] sel = 2'b00;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    logic       rx_read = 1'b0;
    logic       go = 1'b0;
    logic [7:0] peer_byte = 8'h00;
    wire  [7:0] rx_data;
    wire  [7:0] peer_rx;
    wire        tx_ready, tx_busy, rx_valid, rx_ovr, sck_in, sck_out, sck_oe, rxd, txd;
    int         frames;
    int         falls = 0;
    int         errors = 0;
    int         num_checks = 0;
    int         i;
    // 40 MHz clock; falls of the device clock pin are counted
    always #12.5 clk = ~clk;
    always @(negedge sck_out) falls++;
    sync_serial_link i_sync_serial_link
    (
        .CLK_SYS(clk), .SYS_RST(rst), .CLK_SRC_SEL(sel), .HALF_PERIOD(8'h04), .TX_ENABLE(1'b1),
        .RX_ENABLE(1'b1), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_BUSY(tx_busy),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READ(rx_read), .RX_OVERRUN(rx_ovr), .SCK_IN(sck_in),
        .SCK_OUT(sck_out), .SCK_OE(sck_oe), .RXD(rxd), .TXD(txd)
    );
    serial_peer i_serial_peer
    (
        .rst(rst), .sck_oe(sck_oe), .sck_out(sck_out), .txd(txd), .sck_in(sck_in), .rxd(rxd),
        .go(go), .tx_byte(peer_byte), .rx_byte(peer_rx), .frames(frames)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // offer a byte and hold it until the buffer is seen free at an edge
    task automatic put(input logic [7:0] b);
        int k;
        @(posedge clk);
        tx_data <= b;
        tx_valid <= 1'b1;
        @(negedge clk);
        for (k = 0; k < 200 && tx_ready !== 1'b1; k++)
            @(negedge clk);
        if (k == 200)
        begin
            errors++;
            stop_test;
        end
        // ready stood high before this edge, so the byte is taken here
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    // read with quiet cycles first, then expect the buffer empty
    task automatic take(input logic [7:0] exp, input logic ovr);
        check(rx_data, exp);
        check({7'h00, rx_ovr}, {7'h00, ovr});
        repeat (2) @(posedge clk);
        rx_read <= 1'b1;
        @(posedge clk);
        rx_read <= 1'b0;
        @(negedge clk);
        check({6'h00, rx_valid, rx_ovr}, 8'h00);
    endtask
    // no data loaded: clock stays high, reset levels hold
    task automatic t_idle;
        repeat (40) @(negedge clk);
        check({1'b0, txd, sck_out, tx_ready, rx_valid, rx_ovr, tx_busy, sck_oe}, 8'h71);
        check(falls[7:0], 8'h00);
    endtask
    // one full-duplex character in the given clock mode
    task automatic t_frame(input logic [1:0] s);
        logic [7:0] d;
        logic [7:0] p;
        int         k;
        d = 8'h35 ^ {s, 6'h00};
        p = 8'hca ^ {s, 6'h00};
        @(posedge clk);
        sel <= s;
        peer_byte <= p;
        falls = 0;
        put(d);
        go <= s[1];
        for (k = 0; k < 400 && rx_valid !== 1'b1; k++)
            @(negedge clk);
        go <= 1'b0;
        if (k == 400)
        begin
            errors++;
            stop_test;
        end
        check(peer_rx, d);
        check({7'h00, txd}, {7'h00, d[7]});
        check(falls[7:0], s[1] ? 8'h00 : 8'h08);
        check({6'h00, sck_out, sck_oe}, {6'h00, 1'b1, !s[1]});
        take(p, 1'b0);
    endtask
    // two bytes back to back; receive left unread, so the second overruns
    task automatic t_stream;
        int f0;
        int k;
        f0 = frames;
        @(posedge clk);
        sel <= 2'b00;
        peer_byte <= 8'h5a;
        falls = 0;
        put(8'h01);
        put(8'h80);
        for (k = 0; k < 400 && rx_ovr !== 1'b1; k++)
            @(negedge clk);
        if (k == 400)
        begin
            errors++;
            stop_test;
        end
        check(frames[7:0] - f0[7:0], 8'h02);
        check(peer_rx, 8'h80);
        check(falls[7:0], 8'h10);
        take(8'h5a, 1'b1);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_idle;
        for (i = 0; i < 4; i++)
            t_frame(i[1:0]);
        t_stream;
        stop_test;
    end
endmodule // sync_serial_link_tb
